// ### mtfc_map.vh
`ifndef MTFC_MAP_VH
`define MTFC_MAP_VH

// ==========================================================
// Register byte offsets.
`define MTFC_FC_CFG_OFS     8'h00
`define MTFC_TX_CFG_OFS     8'h04
`define MTFC_STATUS_OFS     8'h08

// ==========================================================
// Flow-control configuration fields.
`define MTFC_FC_RX_BIT      0
`define MTFC_FC_TX_BIT      1

// ==========================================================
// Transmitter configuration fields.
`define MTFC_TX_RESET_BIT   0
`define MTFC_TX_JUMBO_BIT   1
`define MTFC_TX_CFCS_BIT    2
`define MTFC_TX_ENABLE_BIT  3
`define MTFC_TX_HALF_BIT    4

// ==========================================================
// Status fields.
`define MTFC_ST_BUSY_BIT    0
`define MTFC_ST_PAUSED_BIT  1
`define MTFC_ST_PEND_BIT    2
`define MTFC_ST_OVER_BIT    3

// ==========================================================
// Frame and timing counts in byte times, quanta shift, pause-frame fields and CRC constants.
`define MTFC_MIN_FRAME      16'h003C
`define MTFC_MAX_STD_FRAME  16'h05EE
`define MTFC_FCS_LEN        16'h0004
`define MTFC_IFG_BYTES      4'hC
`define MTFC_QUANTA_SHIFT   6
`define MTFC_PAUSE_TYPE     16'h8808
`define MTFC_PAUSE_OPCODE   16'h0001
`define MTFC_PAUSE_DA       48'h0180C2000001
`define MTFC_CRC_INIT       32'hFFFFFFFF
`define MTFC_CRC_POLY       32'hEDB88320

`endif

// ### mtfc_top.v
// Contract
// - Receive pause parameter sets reset value of receive flow-control enable bit.
// - Receive flow control on and full duplex: received pause suspends transmitter.
// - Receive flow control off: received pause frames are forwarded to client.
// - Transmit pause parameter sets reset value of transmit flow-control enable bit.
// - Transmit flow control on, full duplex: client pause request sends pause frame.
// - Transmit flow control off: client pause requests are ignored entirely.
// - Transmitter reset bit resets engine and restores transmitter settings to defaults.
// - Jumbo enable set: frames longer than standard maximum may be sent.
// - Jumbo enable clear: only frames up to standard maximum are sent.
// - Client FCS enabled: client supplies FCS, MAC generates none.
// - Client FCS disabled: MAC pads short frames, computes and appends FCS.
// - Transmit enable makes transmitter operational when set, disabled when clear.
// - Half-duplex bit selects half duplex; full duplex gates flow-control behaviour.
`include "mtfc_map.vh"

module mtfc_top #(
   parameter rx_pause_honor_default    = 1'b0,
   parameter tx_pause_gen_default      = 1'b0,
   parameter tx_engine_reset_default   = 1'b0,
   parameter tx_oversize_allow_default = 1'b0,
   parameter tx_client_fcs_default     = 1'b0,
   parameter tx_engine_enable_default  = 1'b1,
   parameter tx_half_duplex_default    = 1'b0,
   parameter [47:0] station_addr       = 48'h020000000001
) (
   // Clock and reset.
   input  wire        core_clk,
   input  wire        rst,
   // Register port.
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // Client transmit stream.
   input  wire [7:0]  client_tx_data,
   input  wire        client_tx_valid,
   input  wire        client_tx_last,
   output wire        client_tx_ready,
   // Client pause request.
   input  wire        client_pause_request,
   input  wire [15:0] client_pause_value,
   // Received pause frames from the receive path.
   input  wire        rx_pause_valid,
   input  wire [15:0] rx_pause_quanta,
   output reg         rx_pause_fwd_valid,
   output reg  [15:0] rx_pause_fwd_quanta,
   // Line side.
   output reg  [7:0]  line_tx_data,
   output reg         line_tx_en,
   output reg         line_tx_err
);

   // =======================================================
   // States.
   localparam [6:0] ST_IDLE  = 7'h01;
   localparam [6:0] ST_DATA  = 7'h02;
   localparam [6:0] ST_PAD   = 7'h04;
   localparam [6:0] ST_PAUSE = 7'h08;
   localparam [6:0] ST_FCS   = 7'h10;
   localparam [6:0] ST_DROP  = 7'h20;
   localparam [6:0] ST_IFG   = 7'h40;

   // =======================================================
   // Functions.
   function [31:0] crc_byte;
      input [31:0] crc;
      input [7:0]  data;
      integer      i;
      reg   [31:0] c;
      begin
         c = crc ^ {24'h000000, data};
         for (i = 0; i < 8; i = i + 1) begin
            c = c[0] ? ((c >> 1) ^ `MTFC_CRC_POLY) : (c >> 1);
         end
         crc_byte = c;
      end
   endfunction

   function [7:0] pause_byte;
      input [15:0] idx;
      input [15:0] quanta;
      reg   [47:0] da;
      reg   [47:0] sa;
      reg   [15:0] ty;
      reg   [15:0] op;
      begin
         da = `MTFC_PAUSE_DA;
         sa = station_addr;
         ty = `MTFC_PAUSE_TYPE;
         op = `MTFC_PAUSE_OPCODE;
         case (idx)
            16'h0000: pause_byte = da[47:40];
            16'h0001: pause_byte = da[39:32];
            16'h0002: pause_byte = da[31:24];
            16'h0003: pause_byte = da[23:16];
            16'h0004: pause_byte = da[15:8];
            16'h0005: pause_byte = da[7:0];
            16'h0006: pause_byte = sa[47:40];
            16'h0007: pause_byte = sa[39:32];
            16'h0008: pause_byte = sa[31:24];
            16'h0009: pause_byte = sa[23:16];
            16'h000A: pause_byte = sa[15:8];
            16'h000B: pause_byte = sa[7:0];
            16'h000C: pause_byte = ty[15:8];
            16'h000D: pause_byte = ty[7:0];
            16'h000E: pause_byte = op[15:8];
            16'h000F: pause_byte = op[7:0];
            16'h0010: pause_byte = quanta[15:8];
            16'h0011: pause_byte = quanta[7:0];
            default:  pause_byte = 8'h00;
         endcase
      end
   endfunction

   // =======================================================
   // Configuration registers.
   reg        fc_rx_reg;
   reg        fc_tx_reg;
   reg        tx_reset_reg;
   reg        tx_jumbo_reg;
   reg        tx_cfcs_reg;
   reg        tx_enable_reg;
   reg        tx_half_reg;
   reg        over_seen_reg;

   wire wr_fc = reg_wr && (reg_addr == `MTFC_FC_CFG_OFS);
   wire wr_tx = reg_wr && (reg_addr == `MTFC_TX_CFG_OFS);
   wire wr_st = reg_wr && (reg_addr == `MTFC_STATUS_OFS);

   always @(posedge core_clk) begin
      if (rst) begin
         fc_rx_reg <= rx_pause_honor_default;
         fc_tx_reg <= tx_pause_gen_default;
      end else if (wr_fc) begin
         fc_rx_reg <= reg_wdata[`MTFC_FC_RX_BIT];
         fc_tx_reg <= reg_wdata[`MTFC_FC_TX_BIT];
      end
   end

   // While the reset bit stands and no write arrives, every other field is held at its default.
   always @(posedge core_clk) begin
      if (rst || (tx_reset_reg && !wr_tx)) begin
         tx_reset_reg  <= rst ? tx_engine_reset_default : tx_reset_reg;
         tx_jumbo_reg  <= tx_oversize_allow_default;
         tx_cfcs_reg   <= tx_client_fcs_default;
         tx_enable_reg <= tx_engine_enable_default;
         tx_half_reg   <= tx_half_duplex_default;
      end else if (wr_tx) begin
         tx_reset_reg  <= reg_wdata[`MTFC_TX_RESET_BIT];
         tx_jumbo_reg  <= reg_wdata[`MTFC_TX_JUMBO_BIT];
         tx_cfcs_reg   <= reg_wdata[`MTFC_TX_CFCS_BIT];
         tx_enable_reg <= reg_wdata[`MTFC_TX_ENABLE_BIT];
         tx_half_reg   <= reg_wdata[`MTFC_TX_HALF_BIT];
      end
   end

   wire full_duplex = !tx_half_reg;

   // =======================================================
   // Engine state.
   reg [6:0]  state_reg;
   reg [15:0] idx_reg;
   reg [31:0] crc_reg;
   reg [1:0]  fcs_cnt_reg;
   reg [3:0]  ifg_cnt_reg;
   reg [21:0] pause_cnt_reg;
   reg        pend_reg;
   reg [15:0] pend_val_reg;
   reg        req_prev_reg;

   wire engine_rst = rst || tx_reset_reg;
   wire paused     = (pause_cnt_reg != 22'h000000);
   wire take       = client_tx_valid && (state_reg == ST_DATA);
   wire [15:0] idx_inc = (idx_reg == 16'hFFFF) ? idx_reg : idx_reg + 16'h0001;
   wire [15:0] max_len = tx_cfcs_reg ? `MTFC_MAX_STD_FRAME
                                     : `MTFC_MAX_STD_FRAME - `MTFC_FCS_LEN;

   assign client_tx_ready = (state_reg == ST_DATA) || (state_reg == ST_DROP);

   // =======================================================
   // Received pause handling.
   always @(posedge core_clk) begin
      if (engine_rst) begin
         pause_cnt_reg       <= 22'h000000;
         rx_pause_fwd_valid  <= 1'b0;
         rx_pause_fwd_quanta <= 16'h0000;
      end else begin
         rx_pause_fwd_valid <= 1'b0;
         if (rx_pause_valid && fc_rx_reg && full_duplex) begin
            pause_cnt_reg <= {rx_pause_quanta, 6'h00};
         end else if (paused) begin
            pause_cnt_reg <= pause_cnt_reg - 22'h000001;
         end
         if (rx_pause_valid && !fc_rx_reg) begin
            rx_pause_fwd_valid  <= 1'b1;
            rx_pause_fwd_quanta <= rx_pause_quanta;
         end
      end
   end

   // =======================================================
   // Client pause request capture.
   wire req_edge = client_pause_request && !req_prev_reg;
   wire start_pause = pend_reg && (state_reg == ST_IDLE) && tx_enable_reg;

   always @(posedge core_clk) begin
      if (engine_rst) begin
         pend_reg     <= 1'b0;
         pend_val_reg <= 16'h0000;
         req_prev_reg <= 1'b0;
      end else begin
         req_prev_reg <= client_pause_request;
         if (req_edge && fc_tx_reg && full_duplex) begin
            pend_reg     <= 1'b1;
            pend_val_reg <= client_pause_value;
         end else if (start_pause) begin
            pend_reg <= 1'b0;
         end
      end
   end

   // =======================================================
   // Oversize flag; a new event wins over a software clear.
   wire over_evt = take && !client_tx_last && !tx_jumbo_reg && (idx_inc >= max_len);

   always @(posedge core_clk) begin
      if (rst) begin
         over_seen_reg <= 1'b0;
      end else if (over_evt) begin
         over_seen_reg <= 1'b1;
      end else if (wr_st && reg_wdata[`MTFC_ST_OVER_BIT]) begin
         over_seen_reg <= 1'b0;
      end
   end

   // =======================================================
   // Transmit engine.
   always @(posedge core_clk) begin
      if (engine_rst) begin
         state_reg    <= ST_IDLE;
         idx_reg      <= 16'h0000;
         crc_reg      <= `MTFC_CRC_INIT;
         fcs_cnt_reg  <= 2'b00;
         ifg_cnt_reg  <= 4'h0;
         line_tx_data <= 8'h00;
         line_tx_en   <= 1'b0;
         line_tx_err  <= 1'b0;
      end else begin
         line_tx_en  <= 1'b0;
         line_tx_err <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               idx_reg <= 16'h0000;
               crc_reg <= `MTFC_CRC_INIT;
               if (start_pause) begin
                  state_reg <= ST_PAUSE;
               end else if (client_tx_valid && tx_enable_reg && !paused) begin
                  state_reg <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (client_tx_valid) begin
                  line_tx_data <= client_tx_data;
                  line_tx_en   <= 1'b1;
                  crc_reg      <= crc_byte(crc_reg, client_tx_data);
                  idx_reg      <= idx_inc;
                  if (client_tx_last) begin
                     if (tx_cfcs_reg) begin
                        state_reg <= ST_IFG;
                     end else if (idx_inc < `MTFC_MIN_FRAME) begin
                        state_reg <= ST_PAD;
                     end else begin
                        state_reg <= ST_FCS;
                     end
                  end else if (over_evt) begin
                     line_tx_err <= 1'b1;
                     state_reg   <= ST_DROP;
                  end
               end
            end
            ST_PAD: begin
               line_tx_data <= 8'h00;
               line_tx_en   <= 1'b1;
               crc_reg      <= crc_byte(crc_reg, 8'h00);
               idx_reg      <= idx_inc;
               if (idx_inc >= `MTFC_MIN_FRAME) begin
                  state_reg <= ST_FCS;
               end
            end
            ST_PAUSE: begin
               line_tx_data <= pause_byte(idx_reg, pend_val_reg);
               line_tx_en   <= 1'b1;
               crc_reg      <= crc_byte(crc_reg, pause_byte(idx_reg, pend_val_reg));
               idx_reg      <= idx_inc;
               if (idx_inc >= `MTFC_MIN_FRAME) begin
                  state_reg <= ST_FCS;
               end
            end
            ST_FCS: begin
               line_tx_data <= ~crc_reg[7:0];
               line_tx_en   <= 1'b1;
               crc_reg      <= {8'h00, crc_reg[31:8]};
               fcs_cnt_reg  <= fcs_cnt_reg + 2'b01;
               if (fcs_cnt_reg == 2'b11) begin
                  state_reg <= ST_IFG;
               end
            end
            ST_DROP: begin
               if (client_tx_valid && client_tx_last) begin
                  state_reg <= ST_IFG;
               end
            end
            ST_IFG: begin
               fcs_cnt_reg <= 2'b00;
               ifg_cnt_reg <= ifg_cnt_reg + 4'h1;
               if (ifg_cnt_reg == `MTFC_IFG_BYTES - 4'h1) begin
                  ifg_cnt_reg <= 4'h0;
                  state_reg   <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // =======================================================
   // Register read port; unmapped addresses read zero.
   always @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= 32'h00000000;
         case (reg_addr)
            `MTFC_FC_CFG_OFS: begin
               reg_rdata[`MTFC_FC_RX_BIT] <= fc_rx_reg;
               reg_rdata[`MTFC_FC_TX_BIT] <= fc_tx_reg;
            end
            `MTFC_TX_CFG_OFS: begin
               reg_rdata[`MTFC_TX_RESET_BIT]  <= tx_reset_reg;
               reg_rdata[`MTFC_TX_JUMBO_BIT]  <= tx_jumbo_reg;
               reg_rdata[`MTFC_TX_CFCS_BIT]   <= tx_cfcs_reg;
               reg_rdata[`MTFC_TX_ENABLE_BIT] <= tx_enable_reg;
               reg_rdata[`MTFC_TX_HALF_BIT]   <= tx_half_reg;
            end
            `MTFC_STATUS_OFS: begin
               reg_rdata[`MTFC_ST_BUSY_BIT]   <= (state_reg != ST_IDLE);
               reg_rdata[`MTFC_ST_PAUSED_BIT] <= paused;
               reg_rdata[`MTFC_ST_PEND_BIT]   <= pend_reg;
               reg_rdata[`MTFC_ST_OVER_BIT]   <= over_seen_reg;
            end
            default: begin
               reg_rdata <= 32'h00000000;
            end
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule

// ### mtfc_monitor.sv
// =====
// Port checker for the configuration defaults block.
module mtfc_monitor #(
   parameter rx_pause_honor_default = 1'b0, tx_pause_gen_default = 1'b0,
   parameter tx_engine_reset_default = 1'b0, tx_oversize_allow_default = 1'b0,
   parameter tx_client_fcs_default = 1'b0, tx_engine_enable_default = 1'b1,
   parameter tx_half_duplex_default = 1'b0
) (
   // Clock and register port.
   input logic        core_clk,
   input logic        rst,
   input logic [7:0]  reg_addr,
   input logic [31:0] reg_wdata,
   input logic        reg_wr,
   input logic        reg_rd,
   input logic [31:0] reg_rdata,
   // Client side.
   input logic        client_tx_valid,
   input logic        client_tx_ready,
   input logic        client_pause_request,
   // Pause path.
   input logic        rx_pause_valid,
   input logic [15:0] rx_pause_quanta,
   input logic        rx_pause_fwd_valid,
   input logic [15:0] rx_pause_fwd_quanta,
   // Line side.
   input logic [7:0]  line_tx_data,
   input logic        line_tx_en,
   input logic        line_tx_err
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] fc_reg;
   logic [4:0] txc_reg;
   logic [3:0] txd;
   assign txd = {tx_half_duplex_default, tx_engine_enable_default, tx_client_fcs_default, tx_oversize_allow_default};
   // Shadow copies of both configuration registers.
   always @(posedge core_clk) begin
      if (rst) begin
         fc_reg  <= {tx_pause_gen_default, rx_pause_honor_default};
         txc_reg <= {txd, tx_engine_reset_default};
      end else begin
         if (reg_wr && reg_addr == 8'h00) fc_reg <= reg_wdata[1:0];
         if (reg_wr && reg_addr == 8'h04) txc_reg <= reg_wdata[4:0];
         else if (txc_reg[0]) txc_reg[4:1] <= txd;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_req_live;
      $rose(client_pause_request) && !line_tx_en && !client_tx_valid;
   endsequence
   sequence s_req_dead;
      s_req_live ##0 (!fc_reg[1] || txc_reg[4]) ##1 (!client_tx_valid)[*6];
   endsequence
   a_read_flow: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata[1:0] == $past(fc_reg))
      else $error("flow config readback wrong");
   a_read_txcfg: assert property (reg_rd && reg_addr == 8'h04 |=> reg_rdata[4:0] == $past(txc_reg))
      else $error("tx config readback wrong");
   a_fwd_when_off: assert property (rx_pause_valid && !fc_reg[0] |=> rx_pause_fwd_valid
      && rx_pause_fwd_quanta == $past(rx_pause_quanta)) else $error("pause not forwarded");
   a_no_fwd_on: assert property (rx_pause_valid && fc_reg[0] |=> !rx_pause_fwd_valid)
      else $error("honored pause forwarded");
   a_err_only_std: assert property (line_tx_err |-> line_tx_en && !txc_reg[1])
      else $error("oversize abort misplaced");
   a_pause_sent: assert property (s_req_live ##0 (fc_reg[1] && !txc_reg[4] && txc_reg[3] && !txc_reg[0])
      |-> ##[1:40] (line_tx_en && line_tx_data == 8'h01)) else $error("pause frame missing");
   a_pause_ignored: assert property (s_req_dead |-> !line_tx_en)
      else $error("pause request not ignored");
   a_tx_disabled: assert property (client_tx_valid && !txc_reg[3] && !client_tx_ready |=> !client_tx_ready)
      else $error("disabled transmitter took a frame");
   a_soft_reset: assert property (txc_reg[0] |=> !client_tx_ready && !line_tx_en && !line_tx_err)
      else $error("engine active in soft reset");
endmodule

// ### mtfc_client.sv
// =====
// Client logic that supplies frames and pause requests.
module mtfc_client (
   // Control from the bench.
   input  logic        core_clk,
   input  logic        rst,
   input  logic        go,
   input  logic [15:0] len,
   input  logic        pause_go,
   input  logic [15:0] pause_val,
   // Toward the block.
   input  logic        client_tx_ready,
   output logic [7:0]  client_tx_data,
   output logic        client_tx_valid,
   output logic        client_tx_last,
   output logic        client_pause_request,
   output logic [15:0] client_pause_value,
   output logic        done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] idx_reg;
   always @(posedge core_clk) begin
      client_pause_request <= pause_go;
      client_pause_value <= pause_val;
      done <= 1'b0;
      if (rst) begin
         client_tx_valid <= 1'b0;
         client_tx_last <= 1'b0;
         client_tx_data <= 8'h00;
      end else if (go && !client_tx_valid) begin
         idx_reg <= 16'h0000;
         client_tx_valid <= 1'b1;
         client_tx_data <= 8'h01;
         client_tx_last <= len == 16'h0001;
      end else if (client_tx_valid && client_tx_ready) begin
         if (client_tx_last) begin
            client_tx_valid <= 1'b0;
            client_tx_last <= 1'b0;
            done <= 1'b1;
         end else begin
            idx_reg <= idx_reg + 16'h0001;
            client_tx_data <= idx_reg[7:0] + 8'h02;
            client_tx_last <= idx_reg + 16'h0002 == len;
         end
      end else if (!client_tx_valid) client_tx_data <= client_tx_data + 8'h01;
   end
endmodule

// ### mtfc_top_tb.sv
// =====
// Self-checking bench.
module mtfc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
   logic        core_clk, rst, reg_wr, reg_rd, go, pause_go, rx_pause_valid, done;
   logic [7:0]  reg_addr, client_tx_data, line_tx_data;
   logic [31:0] reg_wdata, reg_rdata;
   logic [15:0] len, pause_val, rx_pause_quanta, rx_pause_fwd_quanta, client_pause_value;
   logic        client_tx_valid, client_tx_last, client_tx_ready, client_pause_request;
   logic        rx_pause_fwd_valid, line_tx_en, line_tx_err;
   logic [7:0]  cap [0:2047];
   int          miscompares = 0, tests_run = 0, ncap = 0, nerr = 0;
   localparam logic [7:0] hdr [18] = '{8'h01, 8'h80, 8'hC2, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h01, 8'h88, 8'h08, 8'h00, 8'h01, 8'h00, 8'h03};
   mtfc_top #(.rx_pause_honor_default(1'b1)) mtfc_top_inst (.core_clk, .rst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .client_tx_data, .client_tx_valid, .client_tx_last, .client_tx_ready,
      .client_pause_request, .client_pause_value, .rx_pause_valid, .rx_pause_quanta, .rx_pause_fwd_valid,
      .rx_pause_fwd_quanta, .line_tx_data, .line_tx_en, .line_tx_err);
   mtfc_client mtfc_client_inst (.core_clk, .rst, .go, .len, .pause_go, .pause_val, .client_tx_ready,
      .client_tx_data, .client_tx_valid, .client_tx_last, .client_pause_request, .client_pause_value, .done);
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (line_tx_en) begin
      cap[ncap[10:0]] <= line_tx_data;
      ncap <= ncap + 1;
      nerr <= nerr + int'(line_tx_err);
   end
   task automatic end_of_test;
      if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic clr;
      @(negedge core_clk);
      ncap = 0;
      nerr = 0;
   endtask
   task automatic start(input logic [15:0] n);
      @(posedge core_clk);
      len <= n;
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
   endtask
   task automatic fin;
      int k;
      for (k = 0; k < 4000 && done !== 1'b1; k++) @(negedge core_clk);
      if (done !== 1'b1) begin
         miscompares++;
         end_of_test;
      end
      cyc(80);
   endtask
   task automatic rxp(input logic [15:0] q);
      @(posedge core_clk);
      rx_pause_valid <= 1'b1;
      rx_pause_quanta <= q;
      @(posedge core_clk);
      rx_pause_valid <= 1'b0;
      #1;
   endtask
   task automatic preq;
      clr;
      @(posedge core_clk);
      pause_go <= 1'b1;
      cyc(100);
      pause_go <= 1'b0;
   endtask
   task automatic t_defaults;
      logic [31:0] d;
      rd(8'h00, d);
      `CHK(d, 32'h00000001)
      rd(8'h04, d);
      `CHK(d, 32'h00000008)
      rd(8'h0C, d);
      `CHK(d, 32'h00000000)
   endtask
   task automatic t_pad;
      clr;
      start(16'd10);
      fin;
      `CHK(ncap, 64)
      for (int k = 0; k < 60; k++) `CHK(cap[k], (k < 10) ? 8'(k + 1) : 8'h00)
   endtask
   task automatic t_client_fcs;
      wr(8'h04, 32'h0000000C);
      clr;
      start(16'd64);
      fin;
      `CHK(ncap, 64)
      `CHK(cap[63], 8'h40)
      wr(8'h04, 32'h00000008);
   endtask
   task automatic t_rx_pause;
      logic [31:0] d;
      rxp(16'h0001);
      `CHK(rx_pause_fwd_valid, 1'b0)
      rd(8'h08, d);
      `CHK(d, 32'h00000002)
      clr;
      start(16'd10);
      cyc(40);
      `CHK(ncap, 0)
      fin;
      `CHK(ncap, 64)
      wr(8'h00, 32'h00000000);
      rxp(16'h1234);
      `CHK(rx_pause_fwd_valid, 1'b1)
      `CHK(rx_pause_fwd_quanta, 16'h1234)
   endtask
   task automatic t_pause_tx;
      wr(8'h00, 32'h00000002);
      pause_val <= 16'h0003;
      preq;
      `CHK(ncap, 64)
      for (int k = 0; k < 60; k++) `CHK(cap[k], (k < 18) ? hdr[k] : 8'h00)
      wr(8'h00, 32'h00000000);
      preq;
      `CHK(ncap, 0)
      wr(8'h00, 32'h00000002);
      wr(8'h04, 32'h00000018);
      preq;
      `CHK(ncap, 0)
      wr(8'h04, 32'h00000008);
   endtask
   task automatic t_jumbo;
      logic [31:0] d;
      clr;
      start(16'd1600);
      fin;
      `CHK(nerr, 1)
      rd(8'h08, d);
      `CHK(d, 32'h00000008)
      wr(8'h08, 32'h00000008);
      rd(8'h08, d);
      `CHK(d, 32'h00000000)
      wr(8'h04, 32'h0000000A);
      clr;
      start(16'd1600);
      fin;
      `CHK(nerr, 0)
      `CHK(ncap, 1604)
   endtask
   task automatic t_soft_and_off;
      logic [31:0] d;
      wr(8'h04, 32'h0000001B);
      rd(8'h04, d);
      `CHK(d, 32'h00000009)
      wr(8'h04, 32'h00000008);
      start(16'd200);
      cyc(20);
      wr(8'h04, 32'h00000009);
      cyc(3);
      clr;
      cyc(10);
      `CHK(ncap, 0)
      wr(8'h04, 32'h00000008);
      fin;
      wr(8'h04, 32'h00000000);
      start(16'd5);
      clr;
      cyc(30);
      `CHK(ncap, 0)
      wr(8'h04, 32'h00000008);
      fin;
      `CHK(ncap, 64)
   endtask
   initial begin
      {rst, reg_wr, reg_rd, go, pause_go, rx_pause_valid} = 6'b100000;
      {reg_addr, reg_wdata, len, pause_val, rx_pause_quanta} = 88'h0;
      cyc(12);
      rst <= 1'b0;
      t_defaults;
      t_pad;
      t_client_fcs;
      t_rx_pause;
      t_pause_tx;
      t_jumbo;
      t_soft_and_off;
      end_of_test;
   end
endmodule
bind mtfc_top mtfc_monitor #(.rx_pause_honor_default(rx_pause_honor_default),
   .tx_pause_gen_default(tx_pause_gen_default), .tx_engine_reset_default(tx_engine_reset_default),
   .tx_oversize_allow_default(tx_oversize_allow_default), .tx_client_fcs_default(tx_client_fcs_default),
   .tx_engine_enable_default(tx_engine_enable_default), .tx_half_duplex_default(tx_half_duplex_default))
   mtfc_monitor_inst (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .client_tx_valid,
   .client_tx_ready, .client_pause_request, .rx_pause_valid, .rx_pause_quanta, .rx_pause_fwd_valid,
   .rx_pause_fwd_quanta, .line_tx_data, .line_tx_en, .line_tx_err);
